// ### common/fbcs_pkg.sv
// package of offsets, reset values, field positions and state type for the csr block
package fbcs_pkg;

  // register indices on both access ports (word index, not byte address)
  localparam int unsigned ADDR_W = 9;
  localparam logic [8:0] IDX_PRIMARY   = 9'h000;
  localparam logic [8:0] IDX_LOG_ADDR  = 9'h003;
  localparam logic [8:0] IDX_BCAST     = 9'h007;
  localparam logic [8:0] IDX_ARB_LEVEL = 9'h008;
  localparam logic [8:0] IDX_TMR_CTRL  = 9'h009;
  localparam logic [8:0] IDX_WAIT_LIM  = 9'h01d;
  localparam logic [8:0] IDX_ADDR_LIM  = 9'h01e;
  localparam logic [8:0] IDX_DATA_LIM  = 9'h01f;
  localparam logic [8:0] IDX_IF_STATUS = 9'h020;
  localparam logic [8:0] IDX_IRB_BASE  = 9'h100;

  // primary register field positions
  localparam int unsigned BIT_ERROR    = 0;
  localparam int unsigned BIT_LA_EN    = 1;
  localparam int unsigned BIT_RUN      = 2;
  localparam int unsigned BIT_ALLOC    = 3;
  localparam int unsigned BIT_SR_EN    = 4;
  localparam int unsigned BIT_SR_FLAG  = 5;
  localparam int unsigned BIT_PARITY   = 14;
  localparam int unsigned BIT_ACTIVE   = 15;
  localparam int unsigned BIT_CLR_OFS  = 16;
  localparam int unsigned BIT_CLR_ERR  = 16;
  localparam int unsigned BIT_RESET    = 30;
  localparam int unsigned BIT_CLR_DATA = 31;
  localparam logic [31:0] INTERNAL_MASK = 32'h0000_c03f;

  // interface status register fields
  localparam int unsigned ST_IRQ      = 0;
  localparam int unsigned ST_IRB_LSB  = 4;
  localparam int unsigned ST_TMO_LSB  = 8;

  // reset values
  localparam logic [31:0] RST_LOG_ADDR = 32'h0000_0000;
  localparam logic [15:0] RST_BCAST    = 16'h0000;
  localparam logic [7:0]  RST_ARB      = 8'h00;
  localparam logic [2:0]  RST_TMR      = 3'h0;
  localparam logic [7:0]  RST_LIMIT    = 8'hff;

  // timeout channel numbering
  localparam int unsigned TMO_WAIT = 0;
  localparam int unsigned TMO_ADDR = 1;
  localparam int unsigned TMO_DATA = 2;

  // complete block state
  typedef struct packed {
    logic             strap_seen;
    logic             strap_en;
    logic             err_latch;
    logic             la_en;
    logic             run;
    logic             alloc;
    logic             sr_en;
    logic             sr_flag;
    logic             par_err;
    logic [31:0]      log_addr;
    logic [15:0]      bcast;
    logic [7:0]       arb;
    logic [2:0]       tmr;
    logic [2:0][7:0]  limit;
    logic             timer_prev;
    logic [2:0]       cond_prev;
    logic [2:0][7:0]  cnt;
    logic [2:0]       expired;
    logic [2:0]       timeout;
    logic             clr_err;
    logic             rst_pulse;
    logic             clr_data;
    logic             as_prev;
    logic             irb_hit;
    logic [3:0]       irb_pend;
    logic             irq;
    logic [3:0]       irb_num;
    logic             sl_ack;
    logic             disc;
    logic [31:0]      sl_rdata;
    logic [31:0]      cpu_rdata;
  } fbcs_state_s;

endpackage : fbcs_pkg

// ### design/fbcs_csr_block.sv
// control/status register bank of the bus master interface, slave and processor side
//
// Summary of operation
// - primary write bits 16/30/31 pulse clear-error, reset, clear-data, also output.
// - clear-error pulse clears simulated-error latch and parity-error bit 14.
// - reset output is bit-30 write pulse ORed with power-up.
// - clear-data output comes only from bit-31 write pulse.
// - bus reset clears logical-addressing enable bit 1 and run bit 2.
// - bus reset disconnects slave; no address or data acknowledge given.
// - strap enables or disables all internal primary register logic.
// - logical address register, 32 bits, slave port only.
// - broadcast class register, 16 bits, slave port only.
// - arbitration level register, 8 bits, both ports.
// - timer control register, 3 bits, both ports.
// - wait limit bounds timer transitions while wait high; excess flags timeout.
// - address limit bounds transitions while sync high, ack low; excess flags timeout.
// - data limit bounds transitions while data sync and ack differ.
// - sixteen external interrupt receiver blocks in control space.
// - at sync falling edge after receiver block access, interrupt and latch number.
// - no data space storage here; data space served outside.
// - error bit 0 reads application error ORed with simulated-error latch.
// - application drives id during primary read; internal bits override its bits.
`timescale 1ns/100ps

module fbcs_csr_block #(
  parameter int unsigned IRB_COUNT = 16
) (
  // clock, reset, enable
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        clk_en,
  // strap and power
  input  wire logic        primary_reg_strap,
  input  wire logic        power_up,
  // bus slave register port
  input  wire logic        sl_access,
  input  wire logic        sl_write,
  input  wire logic [8:0]  sl_addr,
  input  wire logic [31:0] sl_wdata,
  output logic      [31:0] sl_rdata,
  output logic             sl_ack,
  output logic             sl_disconnect,
  // local processor register port
  input  wire logic        cpu_access,
  input  wire logic        cpu_write,
  input  wire logic [8:0]  cpu_addr,
  input  wire logic [31:0] cpu_wdata,
  output logic      [31:0] cpu_rdata,
  // bus line monitors and timer
  input  wire logic        bus_as,
  input  wire logic        bus_ak,
  input  wire logic        bus_ds,
  input  wire logic        bus_dk,
  input  wire logic        bus_wt,
  input  wire logic        timer_in,
  // application side
  input  wire logic        reset_bus,
  input  wire logic        set_error_flag,
  input  wire logic        set_halt,
  input  wire logic        set_sr,
  input  wire logic        set_parity_error,
  input  wire logic        active,
  input  wire logic [31:0] app_rdata,
  output logic             primary_reg_write_strobe,
  output logic             primary_reg_read_strobe,
  output logic             clear_error,
  output logic             reset_out,
  output logic             clear_data,
  output logic             logical_addr_en,
  output logic             running,
  output logic             sr_flag,
  output logic             parity_error,
  // timeouts and interrupt
  output logic             wait_timeout,
  output logic             addr_timeout,
  output logic             data_timeout,
  output logic             interface_irq,
  output logic      [3:0]  irb_number
);

  // refuse receiver block counts the 4-bit block number cannot serve
  if (IRB_COUNT < 1 || IRB_COUNT > 16) begin : g_bad_irb_count
    $error("IRB_COUNT must lie in 1..16");
  end

  fbcs_pkg::fbcs_state_s q;
  fbcs_pkg::fbcs_state_s next_q;

  // true when an index addresses a receiver block that exists
  function automatic logic irb_hit_f(input logic [8:0] a);
    irb_hit_f = a[8] && ({1'b0, a[7:4]} < 5'(IRB_COUNT));
  endfunction : irb_hit_f

  // primary register value as read, internal bits overriding application bits
  function automatic logic [31:0] primary_f(input fbcs_pkg::fbcs_state_s s,
                                            input logic [31:0]          app,
                                            input logic                 err_in,
                                            input logic                 act);
    logic [31:0] v;
    v = app;
    if (s.strap_en) begin
      v = app & ~fbcs_pkg::INTERNAL_MASK;
      v[fbcs_pkg::BIT_ERROR]   = err_in | s.err_latch;
      v[fbcs_pkg::BIT_LA_EN]   = s.la_en;
      v[fbcs_pkg::BIT_RUN]     = s.run;
      v[fbcs_pkg::BIT_ALLOC]   = s.alloc;
      v[fbcs_pkg::BIT_SR_EN]   = s.sr_en;
      v[fbcs_pkg::BIT_SR_FLAG] = s.sr_flag;
      v[fbcs_pkg::BIT_PARITY]  = s.par_err;
      v[fbcs_pkg::BIT_ACTIVE]  = act;
    end
    primary_f = v;
  endfunction : primary_f

  // read mux shared by both ports; slave_side opens the slave-only registers
  function automatic logic [31:0] read_f(input fbcs_pkg::fbcs_state_s s,
                                         input logic [8:0]            a,
                                         input logic                  slave_side,
                                         input logic [31:0]           prim);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      fbcs_pkg::IDX_PRIMARY:   v = prim;
      fbcs_pkg::IDX_LOG_ADDR:  v = slave_side ? s.log_addr : 32'h0000_0000;
      fbcs_pkg::IDX_BCAST:     v = slave_side ? {16'h0000, s.bcast} : 32'h0000_0000;
      fbcs_pkg::IDX_ARB_LEVEL: v = {24'h000000, s.arb};
      fbcs_pkg::IDX_TMR_CTRL:  v = {29'h00000000, s.tmr};
      fbcs_pkg::IDX_WAIT_LIM:  v = {24'h000000, s.limit[fbcs_pkg::TMO_WAIT]};
      fbcs_pkg::IDX_ADDR_LIM:  v = {24'h000000, s.limit[fbcs_pkg::TMO_ADDR]};
      fbcs_pkg::IDX_DATA_LIM:  v = {24'h000000, s.limit[fbcs_pkg::TMO_DATA]};
      fbcs_pkg::IDX_IF_STATUS: begin
        v[fbcs_pkg::ST_IRQ] = s.irq;
        v[fbcs_pkg::ST_IRB_LSB +: 4] = s.irb_num;
        v[fbcs_pkg::ST_TMO_LSB +: 3] = s.expired;
      end
      default:                 v = 32'h0000_0000;
    endcase
    read_f = v;
  endfunction : read_f

  logic        sl_go;
  logic        sl_wr;
  logic        cpu_wr;
  logic        prim_wr;
  logic [31:0] prim_wdata;
  logic [31:0] prim_rd;
  logic [2:0]  cond;
  logic        tick;

  // access qualification; bus reset shuts the slave port out entirely
  // slave disconnect
  assign sl_go  = sl_access && !reset_bus;
  assign sl_wr  = sl_go && sl_write;
  assign cpu_wr = cpu_access && cpu_write;
  // slave write wins when both ports hit the primary register together
  assign prim_wr    = (sl_wr && sl_addr == fbcs_pkg::IDX_PRIMARY)
                   || (cpu_wr && cpu_addr == fbcs_pkg::IDX_PRIMARY);
  assign prim_wdata = (sl_wr && sl_addr == fbcs_pkg::IDX_PRIMARY) ? sl_wdata : cpu_wdata;
  assign prim_rd    = primary_f(q, app_rdata, set_error_flag, active);

  // bus conditions watched by the three timeout counters
  assign cond[fbcs_pkg::TMO_WAIT] = bus_wt;
  assign cond[fbcs_pkg::TMO_ADDR] = bus_as && !bus_ak;
  assign cond[fbcs_pkg::TMO_DATA] = bus_ds ^ bus_dk;
  assign tick = timer_in ^ q.timer_prev;

  // next-state logic
  always_comb begin
    next_q = q;
    next_q.clr_err   = 1'b0;
    next_q.rst_pulse = 1'b0;
    next_q.clr_data  = 1'b0;
    next_q.timeout   = 3'b000;
    next_q.sl_ack    = 1'b0;

    if (!q.strap_seen) begin
      next_q.strap_seen = 1'b1;
      next_q.strap_en   = primary_reg_strap;
    end

    if (prim_wr && q.strap_en) begin
      next_q.clr_err   = prim_wdata[fbcs_pkg::BIT_CLR_ERR];
      next_q.rst_pulse = prim_wdata[fbcs_pkg::BIT_RESET];
      next_q.clr_data  = prim_wdata[fbcs_pkg::BIT_CLR_DATA];
      // low half sets a bit, the matching high half clears it
      if (prim_wdata[fbcs_pkg::BIT_ERROR]) next_q.err_latch = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_LA_EN + fbcs_pkg::BIT_CLR_OFS]) next_q.la_en = 1'b0;
      if (prim_wdata[fbcs_pkg::BIT_LA_EN]) next_q.la_en = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_RUN + fbcs_pkg::BIT_CLR_OFS]) next_q.run = 1'b0;
      if (prim_wdata[fbcs_pkg::BIT_RUN]) next_q.run = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_ALLOC + fbcs_pkg::BIT_CLR_OFS]) next_q.alloc = 1'b0;
      if (prim_wdata[fbcs_pkg::BIT_ALLOC]) next_q.alloc = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_SR_EN + fbcs_pkg::BIT_CLR_OFS]) next_q.sr_en = 1'b0;
      if (prim_wdata[fbcs_pkg::BIT_SR_EN]) next_q.sr_en = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_SR_FLAG + fbcs_pkg::BIT_CLR_OFS]) next_q.sr_flag = 1'b0;
      if (prim_wdata[fbcs_pkg::BIT_SR_FLAG]) next_q.sr_flag = 1'b1;
      if (prim_wdata[fbcs_pkg::BIT_CLR_ERR]) begin
        next_q.err_latch = 1'b0;
        next_q.par_err   = 1'b0;
      end
    end

    // application events set flags after any clear, so the set wins
    if (q.strap_en) begin
      if (set_parity_error) next_q.par_err = 1'b1;
      if (set_sr) next_q.sr_flag = 1'b1;
      if (set_halt) next_q.run = 1'b0;
    end else begin
      next_q.err_latch = 1'b0;
      next_q.la_en     = 1'b0;
      next_q.run       = 1'b0;
      next_q.alloc     = 1'b0;
      next_q.sr_en     = 1'b0;
      next_q.sr_flag   = 1'b0;
      next_q.par_err   = 1'b0;
    end

    if (reset_bus) begin
      next_q.la_en = 1'b0;
      next_q.run   = 1'b0;
    end
    next_q.disc = reset_bus;

    // slave-only and shared registers; slave write applied last so it wins
    if (cpu_wr) begin
      unique case (cpu_addr)
        fbcs_pkg::IDX_ARB_LEVEL: next_q.arb = cpu_wdata[7:0];
        fbcs_pkg::IDX_TMR_CTRL:  next_q.tmr = cpu_wdata[2:0];
        fbcs_pkg::IDX_WAIT_LIM:  next_q.limit[fbcs_pkg::TMO_WAIT] = cpu_wdata[7:0];
        fbcs_pkg::IDX_ADDR_LIM:  next_q.limit[fbcs_pkg::TMO_ADDR] = cpu_wdata[7:0];
        fbcs_pkg::IDX_DATA_LIM:  next_q.limit[fbcs_pkg::TMO_DATA] = cpu_wdata[7:0];
        default: ;
      endcase
    end
    if (sl_wr) begin
      unique case (sl_addr)
        fbcs_pkg::IDX_LOG_ADDR:  next_q.log_addr = sl_wdata;
        fbcs_pkg::IDX_BCAST:     next_q.bcast = sl_wdata[15:0];
        fbcs_pkg::IDX_ARB_LEVEL: next_q.arb = sl_wdata[7:0];
        fbcs_pkg::IDX_TMR_CTRL:  next_q.tmr = sl_wdata[2:0];
        fbcs_pkg::IDX_WAIT_LIM:  next_q.limit[fbcs_pkg::TMO_WAIT] = sl_wdata[7:0];
        fbcs_pkg::IDX_ADDR_LIM:  next_q.limit[fbcs_pkg::TMO_ADDR] = sl_wdata[7:0];
        fbcs_pkg::IDX_DATA_LIM:  next_q.limit[fbcs_pkg::TMO_DATA] = sl_wdata[7:0];
        default: ;
      endcase
    end

    // read answers, one cycle after the access
    // only control space answers
    if (sl_go) begin
      next_q.sl_ack   = 1'b1;
      next_q.sl_rdata = read_f(q, sl_addr, 1'b1, prim_rd);
    end
    if (cpu_access && !cpu_write) begin
      next_q.cpu_rdata = read_f(q, cpu_addr, 1'b0, prim_rd);
    end

    next_q.timer_prev = timer_in;
    next_q.cond_prev  = cond;
    for (int i = 0; i < 3; i++) begin
      if (cond[i] && !q.cond_prev[i]) begin
        next_q.cnt[i]     = 8'h00;
        next_q.expired[i] = 1'b0;
      end else if (cond[i] && tick && !q.expired[i]) begin
        if (q.cnt[i] == q.limit[i]) begin
          next_q.expired[i] = 1'b1;
          next_q.timeout[i] = 1'b1;
        end else begin
          next_q.cnt[i] = q.cnt[i] + 8'h01;
        end
      end
    end

    // receiver block access remembered until the sync falls
    next_q.as_prev = bus_as;
    if (sl_go && irb_hit_f(sl_addr)) begin
      next_q.irb_hit  = 1'b1;
      next_q.irb_pend = sl_addr[7:4];
    end
    // processor read of the status register clears the interrupt
    if (cpu_access && !cpu_write && cpu_addr == fbcs_pkg::IDX_IF_STATUS) begin
      next_q.irq = 1'b0;
    end
    if (q.as_prev && !bus_as && q.irb_hit) begin
      next_q.irq     = 1'b1;
      next_q.irb_num = q.irb_pend;
      next_q.irb_hit = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      q          <= '0;
      q.log_addr <= fbcs_pkg::RST_LOG_ADDR;
      q.bcast    <= fbcs_pkg::RST_BCAST;
      q.arb      <= fbcs_pkg::RST_ARB;
      q.tmr      <= fbcs_pkg::RST_TMR;
      q.limit    <= {3{fbcs_pkg::RST_LIMIT}};
    end else if (clk_en) begin
      q <= next_q;
    end
  end

  // primary strobes to the application
  assign primary_reg_write_strobe = prim_wr;
  assign primary_reg_read_strobe  = (sl_go && !sl_write && sl_addr == fbcs_pkg::IDX_PRIMARY)
                                 || (cpu_access && !cpu_write
                                     && cpu_addr == fbcs_pkg::IDX_PRIMARY);

  // registered outputs; reset_out also ORs in power_up unregistered
  assign clear_error = q.clr_err;
  assign reset_out   = q.rst_pulse | power_up;
  assign clear_data  = q.clr_data;
  assign logical_addr_en = q.la_en;
  assign running         = q.run;
  assign sr_flag         = q.sr_flag;
  assign parity_error    = q.par_err;
  assign sl_rdata        = q.sl_rdata;
  assign sl_ack          = q.sl_ack;
  assign sl_disconnect   = q.disc;
  assign cpu_rdata       = q.cpu_rdata;
  assign wait_timeout    = q.timeout[fbcs_pkg::TMO_WAIT];
  assign addr_timeout    = q.timeout[fbcs_pkg::TMO_ADDR];
  assign data_timeout    = q.timeout[fbcs_pkg::TMO_DATA];
  assign interface_irq   = q.irq;
  assign irb_number      = q.irb_num;

endmodule : fbcs_csr_block

// ### dv/fbcs_app_model.sv
// application-side model: id on primary reads, error source, integrated bus reset
`timescale 1ns/100ps
module fbcs_app_model #(
  parameter logic [31:0] DEV_ID = 32'h5a5a_0a00, // arbitrary identity value
  parameter int unsigned INTEG  = 3
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset_n,
  // bench requests
  input  wire logic        err_req,
  input  wire logic        halt_req,
  // device side
  input  wire logic        primary_reg_read_strobe,
  input  wire logic        clear_error,
  output logic             set_error_flag,
  output logic             reset_bus,
  output logic      [31:0] app_rdata
);
  int unsigned held;

  // id on read
  // id only inside the read strobe, inverse pattern otherwise
  assign app_rdata = primary_reg_read_strobe ? DEV_ID : ~DEV_ID;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      set_error_flag <= 1'b0;
      reset_bus      <= 1'b0;
      held           <= 0;
    end else begin
      set_error_flag <= (set_error_flag | err_req) & ~clear_error;
      held           <= halt_req ? held + 1 : 0;
      reset_bus      <= halt_req && (held >= INTEG);
    end
  end
endmodule : fbcs_app_model

// ### dv/fbcs_csr_block_bench.sv
// self-checking bench of the csr block with its application model
`timescale 1ns/100ps
module fbcs_csr_block_bench;
  localparam logic [31:0] ID   = 32'h5a5a_0a00; // arbitrary identity value
  localparam logic [31:0] IDP  = ID & ~fbcs_pkg::INTERNAL_MASK;
  localparam logic [31:0] PAT  = 32'ha5c3_9617;
  logic clk = 0, reset_n = 0, clk_en = 1, primary_reg_strap = 1, power_up = 1;
  logic sl_access = 0, sl_write = 0, cpu_access = 0, cpu_write = 0, sl_ack, sl_disconnect;
  logic [8:0] sl_addr = 0, cpu_addr = 0;
  logic [31:0] sl_wdata = 0, cpu_wdata = 0, sl_rdata, cpu_rdata, app_rdata, rd, crd;
  logic bus_as = 0, bus_ak = 0, bus_ds = 0, bus_dk = 0, bus_wt = 0, timer_in = 0;
  logic set_halt = 0, set_sr = 0, set_parity_error = 0, active = 1, err_req = 0, halt_req = 0;
  logic reset_bus, set_error_flag, primary_reg_write_strobe, primary_reg_read_strobe;
  logic clear_error, reset_out, clear_data, logical_addr_en, running, sr_flag, parity_error;
  logic wait_timeout, addr_timeout, data_timeout, interface_irq, ackd;
  logic [3:0] irb_number;
  logic [2:0] pl;
  logic [8:0] idx [8] = '{9'h003, 9'h007, 9'h008, 9'h009, 9'h01d, 9'h01e, 9'h01f, 9'h050};
  logic [31:0] rst [8] = '{0, 0, 0, 0, 32'hff, 32'hff, 32'hff, 0};
  logic [31:0] msk [8] = '{32'hffffffff, 32'hffff, 32'hff, 32'h7, 32'hff, 32'hff, 32'hff, 0};
  int fails = 0;
  int samples_checked = 0;
  int k;
  int n;

  fbcs_csr_block u_fbcs_csr_block (.*);
  fbcs_app_model #(.DEV_ID(ID)) u_fbcs_app_model (.*);

  // free-running clock
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic chk_word(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk_word

  task automatic chk_bit(input string nm, input logic exp, input logic got);
    chk_word(nm, {31'h0, exp}, {31'h0, got});
  endtask : chk_bit

  task automatic test_done;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // a wait that used up its bound ends the run as failed
  task automatic give_up(input logic ok);
    if (!ok) begin
      fails++;
      test_done();
    end
  endtask : give_up

  task automatic do_reset(input logic s);
    @(negedge clk);
    reset_n = 1'b0;
    primary_reg_strap = s;
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    repeat (2) @(negedge clk);
  endtask : do_reset

  // one slave access: request for one cycle, answer sampled the cycle after
  task automatic sl_xfer(input logic wr, input logic [8:0] a, input logic [31:0] d);
    @(negedge clk);
    sl_access = 1'b1;
    sl_write  = wr;
    sl_addr   = a;
    sl_wdata  = d;
    @(negedge clk);
    sl_access = 1'b0;
    rd   = sl_rdata;
    ackd = sl_ack;
    pl   = {clear_error, reset_out, clear_data};
  endtask : sl_xfer

  task automatic cpu_xfer(input logic wr, input logic [8:0] a, input logic [31:0] d);
    @(negedge clk);
    cpu_access = 1'b1;
    cpu_write  = wr;
    cpu_addr   = a;
    cpu_wdata  = d;
    @(negedge clk);
    cpu_access = 1'b0;
    crd = cpu_rdata;
  endtask : cpu_xfer

  // raise one timeout condition, toggle the timer, count changes up to the pulse
  task automatic tmo_run(input int ch, input int lim);
    int seen;
    logic [2:0] v;
    seen = 0;
    v = 3'b000;
    @(negedge clk);
    bus_wt = (ch == 0);
    bus_as = (ch == 1);
    bus_ds = (ch == 2);
    for (int t = 1; t <= 8 && seen == 0; t++) begin
      @(negedge clk);
      timer_in = ~timer_in;
      repeat (3) begin
        @(negedge clk);
        if ({wait_timeout, addr_timeout, data_timeout} != 3'b000) begin
          seen = t;
          v = {wait_timeout, addr_timeout, data_timeout};
        end
      end
    end
    bus_wt = 1'b0;
    bus_as = 1'b0;
    bus_ds = 1'b0;
    chk_word("timer changes", 32'(lim + 1), 32'(seen));
    chk_word("timeout kind", {29'h0, 3'b100 >> ch}, {29'h0, v});
    give_up(seen != 0);
  endtask : tmo_run

  initial begin
    do_reset(1'b1);
    chk_bit("reset_out", 1'b1, reset_out);
    power_up = 1'b0;
    @(negedge clk);
    chk_bit("reset_out", 1'b0, reset_out);
    // reset values, widths, port reach
    for (k = 0; k < 8; k++) begin
      sl_xfer(1'b0, idx[k], 0);
      chk_word("reset value", rst[k], rd);
      sl_xfer(1'b1, idx[k], PAT);
      chk_bit("slave ack", 1'b1, ackd);
      cpu_xfer(1'b1, idx[k], ~PAT);
      cpu_xfer(1'b0, idx[k], 0);
      chk_word("cpu read", (k < 2) ? 0 : ~PAT & msk[k], crd);
      sl_xfer(1'b0, idx[k], 0);
      chk_word("slave read", ((k < 2) ? PAT : ~PAT) & msk[k], rd);
    end
    // primary bits, error flag, parity, clear error
    sl_xfer(1'b1, fbcs_pkg::IDX_PRIMARY, 32'h0000_003f);
    chk_bit("sr_flag", 1'b1, sr_flag);
    sl_xfer(1'b0, fbcs_pkg::IDX_PRIMARY, 0);
    chk_word("primary", IDP | 32'h0000_803f, rd);
    @(negedge clk);
    set_parity_error = 1'b1;
    err_req = 1'b1;
    @(negedge clk);
    set_parity_error = 1'b0;
    err_req = 1'b0;
    chk_bit("parity_error", 1'b1, parity_error);
    sl_xfer(1'b1, fbcs_pkg::IDX_PRIMARY, 32'h0001_0000);
    chk_word("pulses", 3'b100, pl);
    sl_xfer(1'b0, fbcs_pkg::IDX_PRIMARY, 0);
    chk_word("primary", IDP | 32'h0000_803e, rd);
    err_req = 1'b1;
    @(negedge clk);
    err_req = 1'b0;
    sl_xfer(1'b0, fbcs_pkg::IDX_PRIMARY, 0);
    chk_word("primary", IDP | 32'h0000_803f, rd);
    // bus reset
    chk_bit("running", 1'b1, running);
    halt_req = 1'b1;
    for (n = 0; n < 20 && reset_bus !== 1'b1; n++) @(negedge clk);
    give_up(reset_bus === 1'b1);
    @(negedge clk);
    chk_bit("logical_addr_en", 1'b0, logical_addr_en);
    chk_bit("running", 1'b0, running);
    chk_bit("sl_disconnect", 1'b1, sl_disconnect);
    sl_xfer(1'b1, fbcs_pkg::IDX_ARB_LEVEL, 32'h55);
    chk_bit("slave ack", 1'b0, ackd);
    halt_req = 1'b0;
    repeat (3) @(negedge clk);
    chk_bit("sl_disconnect", 1'b0, sl_disconnect);
    sl_xfer(1'b0, fbcs_pkg::IDX_ARB_LEVEL, 0);
    chk_word("arbitration", ~PAT & 32'hff, rd);
    // timeouts with small limits, wait channel twice
    cpu_xfer(1'b1, fbcs_pkg::IDX_WAIT_LIM, 32'h2);
    cpu_xfer(1'b1, fbcs_pkg::IDX_ADDR_LIM, 32'h1);
    cpu_xfer(1'b1, fbcs_pkg::IDX_DATA_LIM, 32'h0);
    tmo_run(0, 2);
    tmo_run(0, 2);
    tmo_run(1, 1);
    tmo_run(2, 0);
    // interrupt receiver blocks, block 3 and last-but-none boundary
    for (k = 3; k < 16; k += 12) begin
      sl_xfer(1'b1, 9'h100 | 9'(k << 4), 0);
      bus_as = 1'b1;
      @(negedge clk);
      bus_as = 1'b0;
      for (n = 0; n < 10 && interface_irq !== 1'b1; n++) @(negedge clk);
      give_up(interface_irq === 1'b1);
      chk_word("irb_number", 32'(k), {28'h0, irb_number});
      cpu_xfer(1'b0, fbcs_pkg::IDX_IF_STATUS, 0);
      chk_word("status", 32'(k << 4) | 32'h1, crd & 32'h0000_00f1);
      chk_bit("interface_irq", 1'b0, interface_irq);
    end
    // reset and clear data pulses
    sl_xfer(1'b1, fbcs_pkg::IDX_PRIMARY, 32'hc000_0000);
    chk_word("pulses", 3'b011, pl);
    sl_xfer(1'b1, fbcs_pkg::IDX_PRIMARY, 32'h8000_0000);
    chk_word("pulses", 3'b001, pl);
    // internal primary bits strapped off
    active = 1'b0;
    do_reset(1'b0);
    sl_xfer(1'b1, fbcs_pkg::IDX_PRIMARY, 32'h4001_003f);
    chk_word("pulses", 3'b000, pl);
    sl_xfer(1'b0, fbcs_pkg::IDX_PRIMARY, 0);
    chk_word("primary", ID, rd);
    test_done();
  end
endmodule : fbcs_csr_block_bench

// ### dv/fbcs_csr_block_monitor.sv
// port-level checker of the csr block
`timescale 1ns/100ps
module fbcs_csr_block_monitor (
  // clock, reset, strap
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        clk_en,
  input wire logic        primary_reg_strap,
  input wire logic        power_up,
  // slave port
  input wire logic        sl_access,
  input wire logic        sl_write,
  input wire logic [8:0]  sl_addr,
  input wire logic [31:0] sl_wdata,
  input wire logic        sl_ack,
  input wire logic        sl_disconnect,
  // bus lines
  input wire logic        bus_as,
  input wire logic        bus_wt,
  input wire logic        timer_in,
  input wire logic        reset_bus,
  input wire logic        set_parity_error,
  // application outputs
  input wire logic        primary_reg_write_strobe,
  input wire logic        clear_error,
  input wire logic        reset_out,
  input wire logic        clear_data,
  input wire logic        logical_addr_en,
  input wire logic        running,
  input wire logic        parity_error,
  input wire logic        wait_timeout,
  input wire logic        addr_timeout,
  input wire logic        data_timeout,
  input wire logic        interface_irq
);
  logic prim_wr;

  // accepted primary write from the slave port with internal bits present
  assign prim_wr = clk_en && sl_access && sl_write && !reset_bus && primary_reg_strap
                   && (sl_addr == fbcs_pkg::IDX_PRIMARY);

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  a_clear_err_pulse: assert property (prim_wr && sl_wdata[16] |=> clear_error)
    else $error("clear error pulse missing after primary write");
  a_reset_bit_pulse: assert property (prim_wr && sl_wdata[30] |=> reset_out)
    else $error("reset output missing after primary write");
  a_reset_power_or: assert property (power_up |-> reset_out)
    else $error("reset output low while power up high");
  a_clear_data_src: assert property (clear_data |-> $past(primary_reg_write_strobe))
    else $error("clear data without a primary write");
  // a parity event in the clearing cycle wins over the clear
  a_parity_cleared: assert property (clear_error && !$past(set_parity_error) |->
      !parity_error)
    else $error("parity bit still set with clear error");
  a_bus_reset_clears: assert property (clk_en && reset_bus |=>
      sl_disconnect && !logical_addr_en && !running)
    else $error("bus reset left enable, run or connection set");
  a_no_ack_reset: assert property (sl_access && reset_bus |=> !sl_ack)
    else $error("slave acknowledged during bus reset");
  a_ack_next_cycle: assert property (clk_en && sl_access && !reset_bus |=> sl_ack)
    else $error("slave access not acknowledged next cycle");
  a_irq_at_fall: assert property ($rose(interface_irq) |->
      $past(bus_as, 2) && !$past(bus_as))
    else $error("interrupt rose without address sync falling");
  a_wait_tmo_cause: assert property (wait_timeout |->
      $past(bus_wt) && ($past(timer_in) != $past(timer_in, 2)))
    else $error("wait timeout without timer change under wait");
  a_addr_tmo_pulse: assert property (addr_timeout |-> $past(bus_as) ##1 !addr_timeout)
    else $error("address timeout not a single pulse under sync");
endmodule : fbcs_csr_block_monitor

bind fbcs_csr_block fbcs_csr_block_monitor u_fbcs_csr_block_monitor (.*);
